// ### rtl/ioc_osc_control.sv
// Oscillator control register, suspend and wake logic, dither generator, pin use.
// Assumes an APB master on clk and wake/timer inputs from other clock domains.
//
// Operation
// - Bit 7 enables the internal oscillator; reset value 1
// - Bit 6 reads 1 only while oscillator runs at programmed frequency
// - Writing 1 to bit 5 suspends the oscillator until wake
// - Any wake event resumes the oscillator without software help
// - Bit 4 high up to three timer clocks after non-timer wake
// - Bit 3 enables frequency dithering; resets to 0
// - Bits 1:0 post divide: 00 by 8, 01 by 4, 10 by 2, 11 by 1
// - Bit 2 reads zero and ignores writes
// - Crystal or resonator mode takes both crystal pins
// - Capacitor, RC or CMOS mode takes only the crystal output pin
// - Dither is a stepped triangle, period 384 cycles, step every 32
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "ioc_cfg.svh"

module ioc_osc_control #(
    parameter int WAKE_SOURCES = 4,
    parameter int SETTLE_CYCLES = `IOC_SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WAKE_SOURCES-1:0] wakeSources,
    input wire logic wakeTimerEvent,
    input wire logic wakeTimerClk,
    output logic oscRunning,
    output logic oscReady,
    output logic sysClkTick,
    output logic signed [2:0] ditherOffset,
    output ioc_pkg::ioc_pin_use_t pinUse,
    output logic irq
);

    // ****************************************************************
    // Local constants
    // ****************************************************************
    localparam int SYNC_WIDTH = WAKE_SOURCES + 2;
    localparam int DITHER_STEPS = `IOC_DITHER_STEPS;
    localparam int DITHER_AMP = DITHER_STEPS / 4;
    localparam logic [7:0] RESET_CTRL = `IOC_CTRL_RESET;

    // Reset lands in the run state so the ready flag reads 1
    localparam ioc_pkg::ioc_ctrl_state_t RESET_STATE = '{
        fsm: ioc_pkg::IOC_RUN,
        enable: RESET_CTRL[`IOC_BIT_ENABLE],
        suspend: RESET_CTRL[`IOC_BIT_SUSPEND],
        dither: RESET_CTRL[`IOC_BIT_DITHER],
        divSel: `IOC_DIV_RESET,
        default: '0
    };

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire [SYNC_WIDTH-1:0] rawIn;
    wire [SYNC_WIDTH-1:0] syncIn;

    assign rawIn = {wakeTimerClk, wakeTimerEvent, wakeSources};

    // Two flops per asynchronous input; only the second stage feeds logic
    for (genvar i = 0; i < SYNC_WIDTH; i++) begin : g_sync
        logic stage1;
        logic stage2;
        always_ff @(posedge clk) begin
            if (rst) begin
                stage1 <= 1'b0;
                stage2 <= 1'b0;
            end else begin
                stage1 <= rawIn[i];
                stage2 <= stage1;
            end
        end
        assign syncIn[i] = stage2;
    end

    // ****************************************************************
    // Wake decode
    // ****************************************************************
    logic wakeExternal;
    logic wakeTimer;
    logic wakeAny;
    logic timerClkSync;
    logic timerRise;

    // Any source ends suspend; only non-timer ones need the sync wait
    assign wakeExternal = |syncIn[WAKE_SOURCES-1:0];
    assign wakeTimer = syncIn[WAKE_SOURCES];
    assign timerClkSync = syncIn[WAKE_SOURCES+1];
    assign wakeAny = wakeExternal | wakeTimer;

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    logic setupPhase;
    logic accessPhase;
    logic addrHit;
    logic ctrlWrite;
    logic extWrite;
    logic clrWrite;
    logic enWrite;
    logic [`IOC_IRQ_BITS-1:0] clrBits;

    // No wait states: every access phase completes at once
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign addrHit = (paddr == `IOC_CTRL_ADDR) | (paddr == `IOC_EXTCFG_ADDR) |
        (paddr == `IOC_IRQ_STAT_ADDR) | (paddr == `IOC_IRQ_CLR_ADDR) |
        (paddr == `IOC_IRQ_EN_ADDR);
    assign ctrlWrite = accessPhase & pwrite & (paddr == `IOC_CTRL_ADDR);
    assign extWrite = accessPhase & pwrite & (paddr == `IOC_EXTCFG_ADDR);
    assign clrWrite = accessPhase & pwrite & (paddr == `IOC_IRQ_CLR_ADDR);
    assign enWrite = accessPhase & pwrite & (paddr == `IOC_IRQ_EN_ADDR);
    assign clrBits = clrWrite ? pwdata[`IOC_IRQ_BITS-1:0] : 3'h0;
    assign pready = accessPhase;
    assign pslverr = accessPhase & ~addrHit;

    // ****************************************************************
    // State and derived flags
    // ****************************************************************
    ioc_pkg::ioc_ctrl_state_t state;
    ioc_pkg::ioc_ctrl_state_t next_state;
    logic running;
    logic ready;
    logic [7:0] ctrlByte;
    logic [`IOC_IRQ_BITS-1:0] irqSet;
    logic signed [4:0] stepSigned;
    logic signed [4:0] offsetWide;

    // Oscillating while settling or running; ready only once settled
    assign running = (state.fsm == ioc_pkg::IOC_SETTLE) | (state.fsm == ioc_pkg::IOC_RUN);
    assign ready = (state.fsm == ioc_pkg::IOC_RUN);

    // Bit 2 always reads zero
    assign ctrlByte = {state.enable, ready, state.suspend, state.syncFlag,
        state.dither, 1'b0, state.divSel};

    // Triangle from step index: up from -amp to +amp, then back down
    assign stepSigned = $signed({1'b0, state.ditherStep});
    assign offsetWide = (state.ditherStep < 4'(DITHER_STEPS / 2)) ?
        stepSigned - signed'(5'(DITHER_AMP)) :
        signed'(5'(DITHER_STEPS - DITHER_AMP)) - stepSigned;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        irqSet = 3'h0;

        // Software writes; suspend only sticks with the oscillator enabled
        if (ctrlWrite) begin
            next_state.enable = pwdata[`IOC_BIT_ENABLE];
            next_state.suspend = pwdata[`IOC_BIT_SUSPEND] & pwdata[`IOC_BIT_ENABLE];
            next_state.dither = pwdata[`IOC_BIT_DITHER];
            next_state.divSel = pwdata[`IOC_DIV_HI:`IOC_DIV_LO];
        end
        if (extWrite) begin
            next_state.extMode = pwdata[`IOC_EXT_MODE_MSB:0];
        end
        if (enWrite) begin
            next_state.irqEnable = pwdata[`IOC_IRQ_BITS-1:0];
        end

        // Sync flag counts timer clock edges before the wake logic may reset it
        next_state.timerClkPrev = timerClkSync;
        if (state.syncFlag && timerRise) begin
            if (state.syncCount == 2'(`IOC_SYNC_TIMER_CLKS - 1)) begin
                next_state.syncFlag = 1'b0;
                irqSet[`IOC_IRQ_SYNC_DONE] = 1'b1;
            end else begin
                next_state.syncCount = state.syncCount + 2'h1;
            end
        end

        // Oscillator sequencing
        case (state.fsm)
            ioc_pkg::IOC_OFF: begin
                if (state.enable) begin
                    next_state.fsm = ioc_pkg::IOC_SETTLE;
                    next_state.settleCount = 8'h00;
                end
            end
            ioc_pkg::IOC_SETTLE: begin
                if (!state.enable) begin
                    next_state.fsm = ioc_pkg::IOC_OFF;
                end else if (state.suspend) begin
                    next_state.fsm = ioc_pkg::IOC_SUSP;
                end else if (state.settleCount == 8'(SETTLE_CYCLES - 1)) begin
                    next_state.fsm = ioc_pkg::IOC_RUN;
                    irqSet[`IOC_IRQ_READY] = 1'b1;
                end else begin
                    next_state.settleCount = state.settleCount + 8'h01;
                end
            end
            ioc_pkg::IOC_RUN: begin
                if (!state.enable) begin
                    next_state.fsm = ioc_pkg::IOC_OFF;
                end else if (state.suspend) begin
                    next_state.fsm = ioc_pkg::IOC_SUSP;
                end
            end
            ioc_pkg::IOC_SUSP: begin
                if (!state.enable) begin
                    next_state.fsm = ioc_pkg::IOC_OFF;
                end else if (wakeAny) begin
                    // Wake beats a suspend written in the same cycle
                    next_state.fsm = ioc_pkg::IOC_SETTLE;
                    next_state.settleCount = 8'h00;
                    next_state.suspend = 1'b0;
                    irqSet[`IOC_IRQ_WAKE] = 1'b1;
                    if (wakeExternal) begin
                        next_state.syncFlag = 1'b1;
                        next_state.syncCount = 2'h0;
                    end
                end
            end
            default: begin
                next_state.fsm = ioc_pkg::IOC_OFF;
            end
        endcase

        // Dither steps only while settled; limited to a small offset range
        if (state.dither && ready) begin
            if (state.ditherTick == 5'(`IOC_DITHER_UPDATE - 1)) begin
                next_state.ditherTick = 5'h00;
                if (state.ditherStep == 4'(DITHER_STEPS - 1)) begin
                    next_state.ditherStep = 4'h0;
                end else begin
                    next_state.ditherStep = state.ditherStep + 4'h1;
                end
            end else begin
                next_state.ditherTick = state.ditherTick + 5'h01;
            end
            next_state.offset = offsetWide[2:0];
        end else begin
            next_state.ditherTick = 5'h00;
            next_state.ditherStep = 4'h0;
            next_state.offset = 3'sh0;
        end

        // Pins owned by the external oscillator mode
        next_state.pins.crystalInOwned = (state.extMode == `IOC_EXT_XTAL) |
            (state.extMode == `IOC_EXT_XTAL_DIV2);
        next_state.pins.crystalOutOwned = next_state.pins.crystalInOwned |
            (state.extMode == `IOC_EXT_CMOS) | (state.extMode == `IOC_EXT_CMOS_DIV2) |
            (state.extMode == `IOC_EXT_RC) | (state.extMode == `IOC_EXT_CAP);

        // Sticky status; a set in the clear cycle wins
        next_state.irqStatus = (state.irqStatus & ~clrBits) | irqSet;

        // Read data captured in the setup phase, stable through access
        if (setupPhase) begin
            case (paddr)
                `IOC_CTRL_ADDR: next_state.readData = {24'h0, ctrlByte};
                `IOC_EXTCFG_ADDR: next_state.readData = {29'h0, state.extMode};
                `IOC_IRQ_STAT_ADDR: next_state.readData = {29'h0, state.irqStatus};
                `IOC_IRQ_EN_ADDR: next_state.readData = {29'h0, state.irqEnable};
                default: next_state.readData = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign timerRise = timerClkSync & ~state.timerClkPrev;

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = state.readData;
    assign oscRunning = running;
    assign oscReady = ready;
    assign ditherOffset = state.offset;
    assign pinUse = state.pins;
    assign irq = |(state.irqStatus & state.irqEnable);

    // Post scaler runs only on a settled oscillator
    ioc_post_divider u_post_divider (
        .clk(clk),
        .rst(rst),
        .run(ready),
        .divSel(state.divSel),
        .sysClkTick(sysClkTick)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_wake;
        (state.fsm == ioc_pkg::IOC_SUSP) && state.enable && wakeAny;
    endsequence

    sequence s_wake_external;
        s_wake ##0 wakeExternal;
    endsequence

    property p_disable_stops;
        @(posedge clk) disable iff (rst)
        (ctrlWrite && !pwdata[`IOC_BIT_ENABLE]) |-> ##2 !oscRunning;
    endproperty
    a_disable_stops: assert property (p_disable_stops) else $error("oscillator kept running");

    property p_suspend_unready;
        @(posedge clk) disable iff (rst)
        (ctrlWrite && pwdata[`IOC_BIT_SUSPEND] && pwdata[`IOC_BIT_ENABLE]) |-> ##2 !oscReady;
    endproperty
    a_suspend_unready: assert property (p_suspend_unready) else $error("ready during suspend");

    property p_wake_resumes;
        @(posedge clk) disable iff (rst)
        s_wake |=> oscRunning;
    endproperty
    a_wake_resumes: assert property (p_wake_resumes) else $error("wake did not resume");

    property p_wake_clears;
        @(posedge clk) disable iff (rst)
        s_wake |=> !state.suspend;
    endproperty
    a_wake_clears: assert property (p_wake_clears) else $error("suspend bit left set");

    property p_sync_set;
        @(posedge clk) disable iff (rst)
        s_wake_external |=> state.syncFlag;
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("sync flag not raised");

    property p_sync_ends;
        @(posedge clk) disable iff (rst)
        (state.syncFlag && timerRise && !wakeAny &&
            state.syncCount == 2'(`IOC_SYNC_TIMER_CLKS - 1)) |=> !state.syncFlag;
    endproperty
    a_sync_ends: assert property (p_sync_ends) else $error("sync flag held too long");

    property p_unused_zero;
        @(posedge clk) disable iff (rst)
        (setupPhase && paddr == `IOC_CTRL_ADDR) |=> (prdata[`IOC_BIT_UNUSED] == 1'b0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit read as one");

    property p_dither_off;
        @(posedge clk) disable iff (rst)
        !state.dither |=> (ditherOffset == 3'sh0);
    endproperty
    a_dither_off: assert property (p_dither_off) else $error("dither active when off");

    property p_dither_hold;
        @(posedge clk) disable iff (rst)
        (ready && state.dither && state.ditherTick != 5'(`IOC_DITHER_UPDATE - 1)) |=>
            $stable(state.ditherStep);
    endproperty
    a_dither_hold: assert property (p_dither_hold) else $error("dither stepped early");

    property p_pins_crystal;
        @(posedge clk) disable iff (rst)
        (state.extMode == `IOC_EXT_XTAL) |=> (pinUse == 2'b11);
    endproperty
    a_pins_crystal: assert property (p_pins_crystal) else $error("crystal pins not taken");

    property p_pins_single;
        @(posedge clk) disable iff (rst)
        (state.extMode == `IOC_EXT_RC || state.extMode == `IOC_EXT_CMOS) |=> (pinUse == 2'b01);
    endproperty
    a_pins_single: assert property (p_pins_single) else $error("wrong single pin use");

endmodule : ioc_osc_control

// ### pkg/ioc_cfg.svh
// Offsets, field positions, reset values and counts for the oscillator control block.
// Assumes a 32-bit APB with byte addresses; one register per aligned word.
`ifndef IOC_CFG_SVH
`define IOC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define IOC_CTRL_IDX 8'ha9
`define IOC_CTRL_ADDR 12'h2a4
`define IOC_EXTCFG_ADDR 12'h300
`define IOC_IRQ_STAT_ADDR 12'h304
`define IOC_IRQ_CLR_ADDR 12'h308
`define IOC_IRQ_EN_ADDR 12'h30c

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define IOC_BIT_ENABLE 7
`define IOC_BIT_READY 6
`define IOC_BIT_SUSPEND 5
`define IOC_BIT_SYNC 4
`define IOC_BIT_DITHER 3
`define IOC_BIT_UNUSED 2
`define IOC_DIV_HI 1
`define IOC_DIV_LO 0
`define IOC_CTRL_RESET 8'hc0
`define IOC_DIV_RESET 2'h0

// ****************************************************************
// External oscillator modes
// ****************************************************************
`define IOC_EXT_OFF 3'h0
`define IOC_EXT_CMOS 3'h2
`define IOC_EXT_CMOS_DIV2 3'h3
`define IOC_EXT_RC 3'h4
`define IOC_EXT_CAP 3'h5
`define IOC_EXT_XTAL 3'h6
`define IOC_EXT_XTAL_DIV2 3'h7
`define IOC_EXT_MODE_MSB 2

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define IOC_IRQ_READY 0
`define IOC_IRQ_WAKE 1
`define IOC_IRQ_SYNC_DONE 2
`define IOC_IRQ_BITS 3

// ****************************************************************
// Timing counts
// ****************************************************************
`define IOC_DITHER_UPDATE 32
`define IOC_DITHER_PERIOD 384
`define IOC_DITHER_STEPS (`IOC_DITHER_PERIOD / `IOC_DITHER_UPDATE)
`define IOC_SYNC_TIMER_CLKS 3
`define IOC_SETTLE_CYCLES 16

`endif

// ### pkg/ioc_pkg.sv
// Types shared by the oscillator control block and its post divider.
// Assumes ioc_cfg.svh for all numeric constants.
package ioc_pkg;

    // ****************************************************************
    // Oscillator states, one-hot
    // ****************************************************************
    typedef enum logic [3:0] {
        IOC_OFF = 4'h1,
        IOC_SETTLE = 4'h2,
        IOC_RUN = 4'h4,
        IOC_SUSP = 4'h8
    } ioc_state_t;

    // Ownership of the two crystal pins by the external oscillator
    typedef struct packed {
        logic crystalInOwned;
        logic crystalOutOwned;
    } ioc_pin_use_t;

    // Post divider state
    typedef struct packed {
        logic [2:0] count;
        logic tick;
    } ioc_div_state_t;

    // Control block state, registered as one word
    typedef struct packed {
        ioc_state_t fsm;
        logic enable;
        logic suspend;
        logic dither;
        logic [1:0] divSel;
        logic syncFlag;
        logic [1:0] syncCount;
        logic [7:0] settleCount;
        logic timerClkPrev;
        logic [2:0] extMode;
        ioc_pin_use_t pins;
        logic [2:0] irqStatus;
        logic [2:0] irqEnable;
        logic [4:0] ditherTick;
        logic [3:0] ditherStep;
        logic signed [2:0] offset;
        logic [31:0] readData;
    } ioc_ctrl_state_t;

endpackage : ioc_pkg

// ### rtl/ioc_post_divider.sv
// Post scaler for the internal oscillator: emits one tick per 8, 4, 2 or 1 cycles.
// Assumes clk stands in for the oscillator and run is high once it has settled.
`timescale 1ns/1ns
`include "ioc_cfg.svh"

module ioc_post_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] divSel,
    output logic sysClkTick
);

    // ****************************************************************
    // State
    // ****************************************************************
    ioc_pkg::ioc_div_state_t state;
    ioc_pkg::ioc_div_state_t next_state;
    logic [2:0] mask;

    // Terminal count per divide code; the counter free-runs so a code change
    // takes effect at once, at the price of one short first period
    always_comb begin
        next_state = state;
        case (divSel)
            2'b00: mask = 3'h7;
            2'b01: mask = 3'h3;
            2'b10: mask = 3'h1;
            2'b11: mask = 3'h0;
            default: mask = 3'h7;
        endcase
        if (run) begin
            next_state.count = state.count + 3'h1;
            next_state.tick = ((state.count & mask) == mask);
        end else begin
            next_state.count = 3'h0;
            next_state.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sysClkTick = state.tick;

    // Code 11 passes every oscillator cycle
    property p_full_rate;
        @(posedge clk) disable iff (rst)
        (run && divSel == 2'b11) |=> sysClkTick;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("post divider missed a tick");

endmodule : ioc_post_divider

// ### testbench/ioc_wake_model.sv
// Wake source model: free timer clock and one wake line that the bench pulses.
// Assumes clk is the bench clock; the timer clock is clk divided by 8.
`timescale 1ns/1ns
module ioc_wake_model (
    input wire logic clk,
    input wire logic fire,
    output logic [3:0] wakeSources,
    output logic wakeTimerEvent,
    output logic wakeTimerClk
);
    logic [2:0] div = 3'h0;
    // Timer clock runs free, unlike a link clock
    always_ff @(posedge clk) begin
        div <= div + 3'h1;
    end
    assign wakeTimerClk = div[2];
    assign wakeSources = {3'h0, fire}; // Non-timer wake only
    assign wakeTimerEvent = 1'b0;
endmodule : ioc_wake_model

// ### testbench/tb_internal_osc_control.sv
// Bench for the oscillator control block over APB.
// Assumes the wake model and the design sources are compiled first.
`timescale 1ns/1ns
`include "ioc_cfg.svh"
module tb_internal_osc_control;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, pready, irq, oscReady;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] ws;
    logic te, tc, tick, run;
    logic signed [2:0] dith;
    ioc_pkg::ioc_pin_use_t pins;
    int fail_count = 0, check_count = 0;
    always #25 clk = ~clk;
    ioc_wake_model wm (.clk(clk), .fire(fire), .wakeSources(ws), .wakeTimerEvent(te),
        .wakeTimerClk(tc));
    ioc_osc_control dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .wakeSources(ws), .wakeTimerEvent(te), .wakeTimerClk(tc),
        .oscRunning(run), .oscReady(oscReady), .sysClkTick(tick), .ditherOffset(dith),
        .pinUse(pins),
        .irq(irq));
    // Hold request until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin fail_count++; $display("mismatch %s exp %h seen %h", n, e, s); end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // Fields, suspend, wake and interrupt in one pass
    task automatic t_main();
        apb(0, `IOC_CTRL_ADDR, 0); chk("reset", r, 32'hc0);
        apb(1, `IOC_CTRL_ADDR, 32'h8f); apb(0, `IOC_CTRL_ADDR, 0);
        chk("fields", r, 32'hcb);
        apb(1, `IOC_IRQ_EN_ADDR, 32'h2);
        apb(1, `IOC_CTRL_ADDR, 32'hab); // Divide by one before suspend
        repeat (4) @(posedge clk);
        chk("susp rdy", oscReady, 0);
        @(posedge clk) fire <= 1;
        @(posedge clk) fire <= 0;
        repeat (60) @(posedge clk); // Past settle and sync span
        apb(0, `IOC_CTRL_ADDR, 0); chk("woke", r, 32'hcb);
        chk("irq", irq, 1);
        apb(1, `IOC_IRQ_CLR_ADDR, 32'h2);
        @(posedge clk);
        chk("irq clr", irq, 0);
    endtask : t_main
    // Post scaler tick counts over 32 cycles
    task automatic t_div();
        int n = 0;
        repeat (32) @(posedge clk) if (tick === 1'b1) n++;
        chk("div1", n, 32);
        apb(1, `IOC_CTRL_ADDR, 32'h88);
        repeat (4) @(posedge clk);
        n = 0;
        repeat (32) @(posedge clk) if (tick === 1'b1) n++;
        chk("div8", n, 4);
    endtask : t_div
    // One full dither period: extremes and number of steps
    task automatic t_dither();
        int mx = -8, mn = 8, steps = 0;
        logic signed [2:0] last;
        last = dith;
        repeat (`IOC_DITHER_PERIOD) begin
            @(posedge clk);
            if (dith !== last) steps++;
            if (dith > mx) mx = dith;
            if (dith < mn) mn = dith;
            last = dith;
        end
        chk("dith steps", steps, `IOC_DITHER_PERIOD / `IOC_DITHER_UPDATE);
        chk("dith max", mx, 3);
        chk("dith min", mn, -3);
        apb(1, `IOC_CTRL_ADDR, 32'h80);
        repeat (3) @(posedge clk);
        chk("dith off", dith, 0);
    endtask : t_dither
    // Pin ownership in crystal, CMOS and off modes; crossbar skip and pin modes are software's part
    task automatic t_pins();
        apb(1, `IOC_EXTCFG_ADDR, {29'h0, `IOC_EXT_XTAL});
        repeat (2) @(posedge clk);
        chk("xtal pins", pins, 2'b11);
        apb(1, `IOC_EXTCFG_ADDR, {29'h0, `IOC_EXT_CMOS});
        repeat (2) @(posedge clk);
        chk("cmos pins", pins, 2'b01);
        apb(0, `IOC_EXTCFG_ADDR, 0); chk("ext mode", r, {29'h0, `IOC_EXT_CMOS});
        apb(1, `IOC_EXTCFG_ADDR, 0);
        repeat (2) @(posedge clk);
        chk("no pins", pins, 2'b00);
    endtask : t_pins
    // Disable and re-enable: ready drops, then returns after settling
    task automatic t_off();
        apb(1, `IOC_CTRL_ADDR, 32'h03);
        repeat (3) @(posedge clk);
        chk("off run", run, 0);
        apb(0, `IOC_CTRL_ADDR, 0); chk("off reg", r, 32'h03);
        apb(1, `IOC_CTRL_ADDR, 32'h83);
        repeat (`IOC_SETTLE_CYCLES + 4) @(posedge clk);
        apb(0, `IOC_CTRL_ADDR, 0); chk("on reg", r, 32'hc3);
    endtask : t_off
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_main();
        t_div();
        t_dither();
        t_pins();
        t_off();
        complete_run();
    end
    initial begin #500000; fail_count++; complete_run(); end
endmodule : tb_internal_osc_control
